// ---- dci_cmd_addr_in.sv ----
module dci_cmd_addr_in (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cs_n_i,
  input wire logic ras_n_i,
  input wire logic cas_n_i,
  input wire logic we_n_i,
  input wire logic cke_i,
  input wire logic odt_i,
  input wire logic [dci_pkg::BA_W-1:0] ba_i,
  input wire logic [dci_pkg::ROW_W-1:0] a_i,
  input wire logic [2*dci_pkg::DQ_W-1:0] wr_pins_i,
  input wire logic [3:0] dm_pins_i,
  input wire logic rd_valid_i,
  output logic rd_ready_o,
  input wire logic [2*dci_pkg::DQ_W-1:0] rd_data_i,
  output logic act_o,
  output logic rd_o,
  output logic wr_o,
  output logic pre_o,
  output logic pre_all_o,
  output logic mrs_o,
  output logic [dci_pkg::BA_W-1:0] bank_o,
  output logic [dci_pkg::ROW_W-1:0] row_o,
  output logic [dci_pkg::COL_W-1:0] col_o,
  output logic auto_pre_o,
  output logic chop_o,
  output logic burst_il_o,
  output logic [dci_pkg::NBANK-1:0] open_o,
  output dci_pkg::dci_pwr_e pwr_o,
  output logic clk_run_o,
  output logic cmd_buf_en_o,
  output logic odt_buf_en_o,
  output logic term_o,
  output logic [3:0] cl_o,
  output logic [3:0] cwl_o,
  output logic [4:0] rl_o,
  output logic [4:0] wl_o,
  output logic dq_oe_o,
  output logic [dci_pkg::DQ_W-1:0] dq_rise_o,
  output logic [dci_pkg::DQ_W-1:0] dq_fall_o,
  output logic rd_miss_o,
  output logic wr_valid_o,
  output logic [2*dci_pkg::DQ_W-1:0] wr_data_o,
  output logic [3:0] wr_be_o
);
  import dci_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    dci_pin_s s1;                   // First sync stage
    dci_pin_s s2;                   // Second sync stage
    dci_pwr_e pwr;                  // Power state
    logic [NBANK-1:0] open;         // Banks with a row open
    logic [NMR-1:0][MR_W-1:0] mr;   // Mode registers
    logic act;
    logic rd;
    logic wr;
    logic pre;
    logic pre_all;
    logic mrs;
    logic [BA_W-1:0] bank;
    logic [ROW_W-1:0] row;
    logic [COL_W-1:0] col;
    logic ap;
    logic chop;
    logic [3:0] cl;
    logic [3:0] cwl;
    logic [4:0] rl;
    logic [4:0] wl;
    logic run;
    logic cmd_en;
    logic odt_en;
    logic term;
    logic [4:0] rd_wait;            // Cycles to first read beat
    logic [2:0] rd_left;            // Read clocks still to drive
    logic rd_chop;
    logic [4:0] wr_wait;            // Cycles to first write beat
    logic [2:0] wr_left;            // Write clocks still to take
    logic wr_chop;
    logic dq_oe;
    logic [DQ_W-1:0] dq_rise;
    logic [DQ_W-1:0] dq_fall;
    logic rd_miss;
    logic wr_valid;
    logic [2*DQ_W-1:0] wr_data;
    logic [3:0] wr_be;
  } dci_st_s;

  dci_st_s q, d;
  dci_pin_s p;                      // Synchronised pin sample
  dci_cmd_e cmd_raw;                // Command as coded on the pins
  dci_cmd_e cmd;                    // Command actually accepted
  logic run_now;                    // Logic clocks running
  logic rd_issue;                   // Drive a read clock this cycle
  logic wr_issue;                   // Take a write clock this cycle
  logic [3:0] al;                   // Additive latency
  logic buf_valid;
  logic [2*DQ_W-1:0] buf_data;
  logic buf_rdy;

  ////////////////////////////////////////////////////////////////////////////
  // Command decode from chip select and the three strobes
  function automatic dci_cmd_e cmd_of(input dci_pin_s s);
    // Deselect masks everything
    if (s.cs_n)
    begin
      return CMD_NOP;
    end
    return dci_cmd_e'({s.ras_n, s.cas_n, s.we_n});
  endfunction

  // Read latency code to cycles
  function automatic logic [3:0] cl_of(input logic [2:0] c);
    return (c == CL_TOP_CODE) ? CL_TOP : CL_BASE + {1'b0, c};
  endfunction

  // Burst chop for one column command
  function automatic logic chop_of(input logic [1:0] bl, input logic a12);
    // Fixed modes ignore the address bit
    return (bl == BL_OTF) ? !a12 : (bl == BL_BC4);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Read data buffer between source and pins
  dci_skid2 #(
    .W(2*DQ_W)
  ) u_rd_buf (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(rd_valid_i),
    .in_ready_o(buf_rdy),
    .in_data_i(rd_data_i),
    .out_valid_o(buf_valid),
    .out_ready_i(rd_issue),
    .out_data_o(buf_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    d = q;
    p = q.s2;
    // All pins sampled on the rising edge, two stages deep
    d.s1 = '{cs_n: cs_n_i, ras_n: ras_n_i, cas_n: cas_n_i, we_n: we_n_i,
             cke: cke_i, odt: odt_i, ba: ba_i, a: a_i,
             wd: wr_pins_i, dm: dm_pins_i};
    d.s2 = q.s1;
    cmd_raw = cmd_of(p);
    // Commands only while running with clock enable high
    run_now = (q.pwr == PW_RUN);
    cmd = (run_now && p.cke) ? cmd_raw : CMD_NOP;
    d.act = 1'b0;
    d.rd = 1'b0;
    d.wr = 1'b0;
    d.pre = 1'b0;
    d.pre_all = 1'b0;
    d.mrs = 1'b0;

    // Power state on clock enable
    unique case (q.pwr)
      PW_RUN:
      begin
        // Enable low: refresh code enters self-refresh
        if (!p.cke)
        begin
          if (!p.cs_n && cmd_raw == CMD_REF)
          begin
            d.pwr = PW_SR;
          end
          else
          begin
            d.pwr = (|q.open) ? PW_PDA : PW_PDP;
          end
        end
      end
      PW_PDP, PW_PDA:
      begin
        // Exit on enable high
        if (p.cke)
        begin
          d.pwr = PW_RUN;
        end
      end
      PW_SR:
      begin
        // Enable is the only live input here
        if (p.cke)
        begin
          d.pwr = PW_RUN;
        end
      end
    endcase

    // Buffer and clock enables follow the next state
    d.run = (d.pwr == PW_RUN);
    d.cmd_en = (d.pwr == PW_RUN);
    d.odt_en = (d.pwr != PW_SR);
    // Termination gated by its buffer and by the mode setting
    d.term = (q.pwr != PW_SR) && p.odt && q.mr[1][MR1_RTT_BIT];

    // Latencies from mode registers
    d.cl = cl_of(q.mr[0][MR0_CL_LSB +: 3]);
    unique case (q.mr[1][MR1_AL_LSB +: 2])
      AL_CL1: al = q.cl - 4'h1;
      AL_CL2: al = q.cl - 4'h2;
      default: al = 4'h0;
    endcase
    d.rl = {1'b0, al} + {1'b0, q.cl};
    d.wl = q.rl - 5'h1;
    d.cwl = CWL_BASE + {1'b0, q.mr[2][MR2_CWL_LSB +: 3]};
    if (d.cwl > CWL_MAX)
    begin
      d.cwl = CWL_MAX;
    end

    // Accepted command
    unique case (cmd)
      CMD_ACT:
      begin
        d.act = 1'b1;
        d.bank = p.ba;
        d.row = p.a;
        d.open[p.ba] = 1'b1;
      end
      CMD_RD, CMD_WR:
      begin
        d.rd = (cmd == CMD_RD);
        d.wr = (cmd == CMD_WR);
        d.bank = p.ba;
        d.col = p.a[COL_W-1:0];
        d.ap = p.a[AP_BIT];
        d.chop = chop_of(q.mr[0][MR0_BL_LSB +: 2], p.a[BC_BIT]);
        // Auto precharge closes the bank
        if (p.a[AP_BIT])
        begin
          d.open[p.ba] = 1'b0;
        end
      end
      CMD_PRE:
      begin
        d.pre = 1'b1;
        d.bank = p.ba;
        d.pre_all = p.a[AP_BIT];
        if (p.a[AP_BIT])
        begin
          d.open = '0;
        end
        else
        begin
          d.open[p.ba] = 1'b0;
        end
      end
      CMD_MRS:
      begin
        // Top bank bit must be low to select a register
        if (!p.ba[BA_W-1])
        begin
          d.mrs = 1'b1;
          d.mr[p.ba[1:0]] = p.a;
        end
      end
      default:
      begin
        // Refresh, calibration and no-operation do nothing here
        d.act = 1'b0;
      end
    endcase

    // Read burst, one in flight; counters stop while clocks are off
    rd_issue = run_now && ((q.rd_wait == 5'h1) || (q.rd_left != 3'h0));
    d.dq_oe = 1'b0;
    d.rd_miss = 1'b0;
    if (run_now)
    begin
      if (d.rd && q.rd_wait == 5'h0 && q.rd_left == 3'h0)
      begin
        d.rd_wait = q.rl;
        d.rd_chop = d.chop;
      end
      else if (q.rd_wait != 5'h0)
      begin
        d.rd_wait = q.rd_wait - 5'h1;
      end
    end
    if (rd_issue)
    begin
      // Two beats per clock, one on each crossing
      d.dq_oe = 1'b1;
      d.dq_rise = buf_data[DQ_W-1:0];
      d.dq_fall = buf_data[2*DQ_W-1:DQ_W];
      d.rd_miss = !buf_valid;
      if (q.rd_wait == 5'h1)
      begin
        d.rd_left = (q.rd_chop ? CLK_BC4 : CLK_BL8) - 3'h1;
      end
      else
      begin
        d.rd_left = q.rd_left - 3'h1;
      end
    end

    // Write burst, one in flight
    wr_issue = run_now && ((q.wr_wait == 5'h1) || (q.wr_left != 3'h0));
    d.wr_valid = 1'b0;
    if (run_now)
    begin
      if (d.wr && q.wr_wait == 5'h0 && q.wr_left == 3'h0)
      begin
        d.wr_wait = q.wl;
        d.wr_chop = d.chop;
      end
      else if (q.wr_wait != 5'h0)
      begin
        d.wr_wait = q.wr_wait - 5'h1;
      end
    end
    if (wr_issue)
    begin
      // Masked lanes lose their byte enable
      d.wr_valid = 1'b1;
      d.wr_data = p.wd;
      d.wr_be = ~p.dm;
      if (q.wr_wait == 5'h1)
      begin
        d.wr_left = (q.wr_chop ? CLK_BC4 : CLK_BL8) - 3'h1;
      end
      else
      begin
        d.wr_left = q.wr_left - 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q <= '0;
      // Sync stages start idle, so no false power-down follows reset
      q.s1 <= PIN_RST;
      q.s2 <= PIN_RST;
    end
    else
    begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign rd_ready_o = buf_rdy;
  assign act_o = q.act;
  assign rd_o = q.rd;
  assign wr_o = q.wr;
  assign pre_o = q.pre;
  assign pre_all_o = q.pre_all;
  assign mrs_o = q.mrs;
  assign bank_o = q.bank;
  assign row_o = q.row;
  assign col_o = q.col;
  assign auto_pre_o = q.ap;
  assign chop_o = q.chop;
  assign burst_il_o = q.mr[0][MR0_BT_BIT];
  assign open_o = q.open;
  assign pwr_o = q.pwr;
  assign clk_run_o = q.run;
  assign cmd_buf_en_o = q.cmd_en;
  assign odt_buf_en_o = q.odt_en;
  assign term_o = q.term;
  assign cl_o = q.cl;
  assign cwl_o = q.cwl;
  assign rl_o = q.rl;
  assign wl_o = q.wl;
  assign dq_oe_o = q.dq_oe;
  assign dq_rise_o = q.dq_rise;
  assign dq_fall_o = q.dq_fall;
  assign rd_miss_o = q.rd_miss;
  assign wr_valid_o = q.wr_valid;
  assign wr_data_o = q.wr_data;
  assign wr_be_o = q.wr_be;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Deselect produces no command pulse
  property p_cs_mask;
    q.s2.cs_n |=> !(q.act || q.rd || q.wr || q.pre || q.mrs);
  endproperty
  a_cs_mask: assert property (p_cs_mask) else $error("command taken while deselected");

  // Activate captures row and bank of the pins
  property p_act_row;
    (q.pwr == PW_RUN && q.s2.cke && cmd_of(q.s2) == CMD_ACT)
      |=> act_o && row_o == $past(q.s2.a) && open_o[bank_o];
  endproperty
  a_act_row: assert property (p_act_row) else $error("activate row wrong");

  // Precharge with bit ten closes every bank
  property p_pre_all;
    (q.pwr == PW_RUN && q.s2.cke && cmd_of(q.s2) == CMD_PRE && q.s2.a[AP_BIT])
      |=> pre_all_o && open_o == '0;
  endproperty
  a_pre_all: assert property (p_pre_all) else $error("precharge all missed");

  // Mode set writes register one
  property p_mr1;
    (q.pwr == PW_RUN && q.s2.cke && cmd_of(q.s2) == CMD_MRS && q.s2.ba == 3'h1)
      |=> mrs_o && q.mr[1] == $past(q.s2.a);
  endproperty
  a_mr1: assert property (p_mr1) else $error("mode register not written");

  // Termination off when mode disables it
  property p_odt_off;
    !q.mr[1][MR1_RTT_BIT] |=> !term_o;
  endproperty
  a_odt_off: assert property (p_odt_off) else $error("termination not disabled");

  // Enable low with open bank gives active power-down
  property p_pda;
    (q.pwr == PW_RUN && !q.s2.cke && cmd_of(q.s2) != CMD_REF && |q.open)
      |=> pwr_o == PW_PDA ##0 !cmd_buf_en_o && odt_buf_en_o;
  endproperty
  a_pda: assert property (p_pda) else $error("active power-down not entered");

  // Self-refresh shuts all buffers and leaves on enable
  property p_sr;
    (pwr_o == PW_SR) |-> ((!cmd_buf_en_o && !odt_buf_en_o && !clk_run_o)
      and (q.s2.cke |=> pwr_o == PW_RUN));
  endproperty
  a_sr: assert property (p_sr) else $error("self-refresh buffers or exit wrong");

  // Read latency then eight or four beats
  sequence s_bl8;
    dq_oe_o [*4] ##1 !dq_oe_o;
  endsequence
  sequence s_bc4;
    dq_oe_o [*2] ##1 !dq_oe_o;
  endsequence
  property p_rd_start;
    (q.rd_wait == 5'h1 && q.pwr == PW_RUN) |=> dq_oe_o;
  endproperty
  a_rd_start: assert property (p_rd_start) else $error("read data late");
  property p_rd_burst;
    (q.rd_wait == 5'h1 && q.pwr == PW_RUN && $stable(q.pwr))
      |=> if (q.rd_chop) s_bc4 else s_bl8;
  endproperty
  a_rd_burst: assert property (p_rd_burst) else $error("read burst length wrong");

  // Write latency one below read latency
  property p_wl;
    (q.pwr == PW_RUN) |-> ##2 (wl_o == $past(rl_o) - 5'h1);
  endproperty
  a_wl: assert property (p_wl) else $error("write latency not read minus one");

  // Masked beat loses its enable
  property p_mask;
    (wr_issue && q.s2.dm[0]) |=> wr_valid_o && !wr_be_o[0];
  endproperty
  a_mask: assert property (p_mask) else $error("masked beat kept");

endmodule

// ---- dci_cmd_addr_in_tb.sv ----
module dci_cmd_addr_in_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dci_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cs_n_i, ras_n_i, cas_n_i, we_n_i, cke_i, odt_i, rd_valid_i, rd_ready_o, stall;
  logic act_o, rd_o, wr_o, pre_o, pre_all_o, mrs_o, auto_pre_o, chop_o, burst_il_o;
  logic clk_run_o, cmd_buf_en_o, odt_buf_en_o, term_o, dq_oe_o, rd_miss_o, wr_valid_o;
  logic [2:0] ba_i, bank_o, b;
  logic pa;
  logic [12:0] a_i, row_o, r;
  logic [31:0] wr_pins_i, rd_data_i, wr_data_o;
  logic [3:0] dm_pins_i, wr_be_o, cl_o, cwl_o;
  logic [9:0] col_o;
  logic [7:0] open_o;
  logic [4:0] rl_o, wl_o;
  logic [15:0] dq_rise_o, dq_fall_o;
  logic [31:0] wd[4];
  logic [3:0] dm[4];
  dci_pwr_e pwr_o;
  int bad_count, tests_run, seed, nw, rl, c;
  ////////////////////////////////////////////////////////////////////////////
  always #5 clk_i = ~clk_i;
  dci_cmd_addr_in dut (.*);
  dci_rd_src u_src (.clk_i(clk_i), .rst_i(rst_i), .stall_i(stall), .ready_i(rd_ready_o),
    .valid_o(rd_valid_i), .data_o(rd_data_i));
  ////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // One command cycle, then deselect; pulses checked three cycles on
  task automatic cmd(input logic [3:0] cc, input logic [2:0] bb, input logic [12:0] ad,
    input logic [4:0] e);
    {cs_n_i, ras_n_i, cas_n_i, we_n_i} = cc;
    ba_i = bb;
    a_i = ad;
    tick(1);
    {cs_n_i, ras_n_i, cas_n_i, we_n_i} = 4'hf;
    a_i = 13'($random(seed));
    tick(2);
    chk("pulses", 32'(e), 32'({act_o, rd_o, wr_o, pre_o, mrs_o}));
    pa = pre_all_o;
    tick(1);
  endtask
  // Read beats from buffer, two per clock
  task automatic burst(input int n);
    tick(rl - 1);
    repeat (n)
    begin
      chk("dq_oe", 1, 32'(dq_oe_o));
      chk("beats", {~16'(nw), 16'(nw)}, {dq_fall_o, dq_rise_o});
      chk("miss", 0, 32'(rd_miss_o));
      nw++;
      tick(1);
    end
    chk("dq_oe end", 0, 32'(dq_oe_o));
  endtask
  task automatic end_of_test();
    $display("Comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    seed = 73;
    {cs_n_i, ras_n_i, cas_n_i, we_n_i, cke_i, odt_i, stall} = 7'h7c;
    {ba_i, a_i, wr_pins_i, dm_pins_i} = '0;
    tick(10);
    rst_i = 1'b0;
    tick(4);
    // Every read latency code, interleaved type
    for (c = 0; c < 8; c++)
    begin
      cmd({1'b0, CMD_MRS}, 3'h0, 13'(c * 16 + 8), 5'h01);
      tick(2);
      chk("cl", (c == 7) ? 13 : 5 + c, 32'(cl_o));
      chk("type", 1, 32'(burst_il_o));
    end
    // Additive latency codes with termination on
    for (c = 0; c < 3; c++)
    begin
      cmd({1'b0, CMD_MRS}, 3'h1, 13'(c * 8 + 4), 5'h01);
      tick(2);
      rl = 13 + ((c == 0) ? 0 : 13 - c);
      chk("rl", rl, 32'(rl_o));
      chk("wl", rl - 1, 32'(wl_o));
    end
    odt_i = 1'b1;
    tick(4);
    chk("term", 1, 32'(term_o));
    cmd({1'b0, CMD_MRS}, 3'h1, 13'h0000, 5'h01);
    tick(2);
    chk("term off", 0, 32'(term_o));
    odt_i = 1'b0;
    c = $random(seed) & 7;
    cmd({1'b0, CMD_MRS}, 3'h2, 13'(c * 8), 5'h01);
    chk("cwl", (c > 4) ? 9 : 5 + c, 32'(cwl_o));
    c = $random(seed) & 7;
    rl = (c == 7) ? 13 : 5 + c;
    cmd({1'b0, CMD_MRS}, 3'h0, 13'(c * 16 + 1), 5'h01);
    tick(2);
    chk("seq", 0, 32'(burst_il_o));
    // Row open, masked command, single precharge
    b = 3'($random(seed));
    r = 13'($random(seed));
    cmd({1'b0, CMD_ACT}, b, r, 5'h10);
    chk("row", r, row_o);
    chk("bank", b, bank_o);
    cmd({1'b1, CMD_ACT}, b + 3'h1, r, 5'h00);
    chk("open", 32'(8'h01 << b), open_o);
    cmd({1'b0, CMD_ACT}, b + 3'h1, ~r, 5'h10);
    cmd({1'b0, CMD_PRE}, b, 13'h0000, 5'h02);
    chk("pre all", 0, 32'(pa));
    chk("open", 32'(8'h01 << (b + 3'h1)), open_o);
    // Full burst from a full buffer, then chopped with auto precharge
    chk("full", 0, 32'(rd_ready_o));
    r = 13'($random(seed)) & 13'h03ff;
    cmd({1'b0, CMD_RD}, b + 3'h1, r | 13'h1000, 5'h08);
    chk("col", r, 32'(col_o));
    chk("chop", 0, 32'({auto_pre_o, chop_o}));
    burst(4);
    stall = 1'b1;
    cmd({1'b0, CMD_RD}, b + 3'h1, r | 13'h0400, 5'h08);
    chk("ap chop", 3, 32'({auto_pre_o, chop_o}));
    chk("closed", 0, 32'(open_o));
    burst(2);
    chk("room", 1, 32'(rd_ready_o));
    stall = 1'b0;
    // Write with random data and masks
    cmd({1'b0, CMD_WR}, b, r | 13'h1000, 5'h04);
    tick(rl - 5);
    for (c = 0; c < 7; c++)
    begin
      if (c < 4)
      begin
        wd[c] = $random(seed);
        dm[c] = 4'($random(seed));
        wr_pins_i = wd[c];
        dm_pins_i = dm[c];
      end
      tick(1);
      if (c >= 2 && c < 6)
      begin
        chk("wr valid", 1, 32'(wr_valid_o));
        chk("wr data", wd[c - 2], wr_data_o);
        chk("wr be", {28'h0, ~dm[c - 2]}, 32'(wr_be_o));
      end
    end
    chk("wr end", 0, 32'(wr_valid_o));
    // Precharge power-down, command ignored inside
    cke_i = 1'b0;
    tick(4);
    chk("pdp", {PW_PDP, 3'h1}, {pwr_o, clk_run_o, cmd_buf_en_o, odt_buf_en_o});
    cmd({1'b0, CMD_ACT}, b, r, 5'h00);
    cke_i = 1'b1;
    tick(4);
    chk("run", {PW_RUN, 3'h7}, {pwr_o, clk_run_o, cmd_buf_en_o, odt_buf_en_o});
    // Active power-down with a row open
    cmd({1'b0, CMD_ACT}, b, r, 5'h10);
    cke_i = 1'b0;
    tick(4);
    chk("pda", PW_PDA, pwr_o);
    cke_i = 1'b1;
    tick(4);
    cmd({1'b0, CMD_PRE}, b, 13'h0400, 5'h02);
    chk("pre all", 32'h100, {pa, open_o});
    // Self-refresh entry and exit
    cke_i = 1'b0;
    cmd({1'b0, CMD_REF}, 3'h0, 13'h0000, 5'h00);
    chk("sr", {PW_SR, 3'h0}, {pwr_o, clk_run_o, cmd_buf_en_o, odt_buf_en_o});
    cke_i = 1'b1;
    tick(4);
    chk("sr exit", PW_RUN, pwr_o);
    end_of_test();
  end
  // Hang guard
  initial
  begin
    #200us;
    bad_count++;
    end_of_test();
  end
endmodule

// ---- dci_pkg.sv ----
package dci_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Array geometry
  localparam int ROW_W = 13;            // Row address width
  localparam int COL_W = 10;            // Column address width
  localparam int BA_W = 3;              // Bank address width
  localparam int NBANK = 8;             // Number of banks
  localparam int DQ_W = 16;             // Data lane width per beat
  localparam int MR_W = 13;             // Mode register width
  localparam int NMR = 4;               // Number of mode registers

  ////////////////////////////////////////////////////////////////////////////
  // Address bit roles
  localparam int AP_BIT = 10;           // Auto precharge / all banks
  localparam int BC_BIT = 12;           // On-the-fly burst chop

  ////////////////////////////////////////////////////////////////////////////
  // Mode register fields
  localparam int MR0_BL_LSB = 0;        // Burst length code, 2 bits
  localparam int MR0_BT_BIT = 3;        // Burst type, 1 = interleaved
  localparam int MR0_CL_LSB = 4;        // Read latency code, 3 bits
  localparam int MR1_RTT_BIT = 2;       // Termination enable
  localparam int MR1_AL_LSB = 3;        // Additive latency code, 2 bits
  localparam int MR2_CWL_LSB = 3;       // Write latency code, 3 bits
  localparam logic [12:0] MR_RST = 13'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Latency figures in clock cycles
  localparam logic [3:0] CL_BASE = 4'h5;
  localparam logic [3:0] CL_TOP = 4'hd;
  localparam logic [2:0] CL_TOP_CODE = 3'h7;
  localparam logic [3:0] CWL_BASE = 4'h5;
  localparam logic [3:0] CWL_MAX = 4'h9;
  localparam logic [1:0] AL_CL1 = 2'h1;
  localparam logic [1:0] AL_CL2 = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Burst settings
  localparam logic [1:0] BL_FIX8 = 2'h0;
  localparam logic [1:0] BL_OTF = 2'h1;
  localparam logic [1:0] BL_BC4 = 2'h2;
  localparam logic [2:0] CLK_BL8 = 3'h4;  // Clocks for eight beats
  localparam logic [2:0] CLK_BC4 = 3'h2;  // Clocks for four beats

  ////////////////////////////////////////////////////////////////////////////
  // Commands, coded as row strobe, column strobe, write enable
  typedef enum logic [2:0] {
    CMD_MRS = 3'h0,
    CMD_REF = 3'h1,
    CMD_PRE = 3'h2,
    CMD_ACT = 3'h3,
    CMD_WR = 3'h4,
    CMD_RD = 3'h5,
    CMD_ZQ = 3'h6,
    CMD_NOP = 3'h7
  } dci_cmd_e;

  // Power states
  typedef enum logic [1:0] {
    PW_RUN = 2'b00,
    PW_PDP = 2'b01,
    PW_SR = 2'b11,
    PW_PDA = 2'b10
  } dci_pwr_e;

  // Pin sample, one per clock
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic cke;
    logic odt;
    logic [BA_W-1:0] ba;
    logic [ROW_W-1:0] a;
    logic [2*DQ_W-1:0] wd;
    logic [3:0] dm;
  } dci_pin_s;

  // Pin sample after reset: deselected, clock enable high
  localparam dci_pin_s PIN_RST = '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
                                   cke: 1'b1, default: '0};

endpackage

// ---- dci_rd_src.sv ----
module dci_rd_src (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic stall_i,
  input wire logic ready_i,
  output logic valid_o,
  output logic [31:0] data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic valid_q; // Word on offer
  logic [15:0] cnt_q; // Words handed over
  ////////////////////////////////////////////////////////////////////////////
  // Offer held until taken; stall only stops new offers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      valid_q <= 1'b0;
      cnt_q <= 16'h0000;
    end
    else
    begin
      if (valid_q && ready_i)
        cnt_q <= cnt_q + 16'h0001;
      if (!valid_q || ready_i)
        valid_q <= !stall_i;
    end
  end
  // Idle word is inverted so it never looks like a fresh one
  assign valid_o = valid_q;
  assign data_o = valid_q ? {~cnt_q, cnt_q} : {cnt_q, ~cnt_q};
endmodule

// ---- dci_skid2.sv ----
module dci_skid2 #(
  parameter int W = 32
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);

  // Two entries, head first
  typedef struct packed {
    logic [W-1:0] e0;
    logic [W-1:0] e1;
    logic [1:0] n;
    logic rdy;
  } dci_skid_s;

  dci_skid_s q, d;
  logic push;
  logic pop;

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    d = q;
    push = in_valid_i && q.rdy;
    pop = out_ready_i && (q.n != 2'h0);
    // Shift head out
    if (pop)
    begin
      d.e0 = q.e1;
    end
    // Write into first free slot after the shift
    if (push)
    begin
      if ((q.n - {1'b0, pop}) == 2'h0)
      begin
        d.e0 = in_data_i;
      end
      else
      begin
        d.e1 = in_data_i;
      end
    end
    d.n = q.n + {1'b0, push} - {1'b0, pop};
    d.rdy = (d.n != 2'h2);
  end

  // State register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q <= '0;
      q.rdy <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  assign in_ready_o = q.rdy;
  assign out_valid_o = (q.n != 2'h0);
  assign out_data_o = q.e0;

endmodule
